// ==== verilog/scts_pkg.sv ====
/*
 * Package for the sensor command and teach status block: register map, command codes, field layouts, timing.
 * Assumes a 100 MHz clock and an APB master with 32-bit data.
 */
// Contract
// [RQ1] Host writes the command argument before the command code; code write triggers.
// [RQ2] Command code write runs teach 3, reboot 4, reset 5, save 6, split 8.
// [RQ3] Reset command erases user settings; factory settings apply at next power-on.
// [RQ4] Host follows a reset command with a reboot to restore factory settings.
// [RQ5] Save takes up to 600 ms; all other traffic is refused meanwhile.
// [RQ6] Split argument bits 7:0 give area count, at most 32, equal areas.
// [RQ7] Argument bit 8 clear: any beam interrupted; set: all beams interrupted.
// [RQ8] Split results are written into the 32 per-area configuration objects.
// [RQ9] Teach status reads 00 ok, 01 busy, 80 error; top bit is error.
// [RQ10] Switch-on thresholds read for 64 beams from the block start beam.
// [RQ11] Switch-off thresholds read for the same 64-beam block.
// [RQ12] Block start beam ranges 1 to 1774, default 1.
// [RQ13] First and last beam signal levels are readable, 16 bits each.
// [RQ14] Reported signal levels scale with the selected function reserve.
// [RQ15] Area object holds active, logic, start, end, on count and off count.
// [RQ16] Reserved codes are ignored; teach status is busy throughout a teach. Code flags a reject event for reserved codes.
// [RQ17] Split with zero or more than 32 areas is rejected, areas unchanged.
`default_nettype none
package scts_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned SAVE_MS = 600;
    localparam int unsigned SAVE_CYCLES = SAVE_MS * (CLK_HZ / 1000);
    localparam int unsigned NUM_BEAMS = 1774;
    localparam int unsigned MAX_AREAS = 32;
    localparam int unsigned BLOCK_BEAMS = 64;

    // Byte addresses: index times four, plus sub-index in the low two bits
    localparam logic [15:0] IDX_ON_THR = 16'h2191;
    localparam logic [15:0] IDX_OFF_THR = 16'h2192;
    localparam logic [15:0] IDX_CMD = 16'h2200;
    localparam logic [15:0] IDX_TEACH = 16'h2400;
    localparam logic [15:0] IDX_LEVEL = 16'h2404;
    localparam logic [15:0] IDX_BLOCK = 16'h2912;
    localparam logic [15:0] IDX_AREA0 = 16'h2170;
    localparam logic [15:0] IDX_IRQ_STAT = 16'h3000;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h3001;
    localparam logic [15:0] IDX_RESERVE = 16'h3002;

    localparam logic [15:0] CMD_TEACH = 16'h0003;
    localparam logic [15:0] CMD_REBOOT = 16'h0004;
    localparam logic [15:0] CMD_RESET = 16'h0005;
    localparam logic [15:0] CMD_SAVE = 16'h0006;
    localparam logic [15:0] CMD_SPLIT = 16'h0008;

    localparam logic [7:0] TEACH_OK = 8'h00;
    localparam logic [7:0] TEACH_BUSY = 8'h01;
    localparam logic [7:0] TEACH_ERR = 8'h80;

    localparam int unsigned ARG_CNT_MSB = 7;
    localparam int unsigned ARG_AND_BIT = 8;
    localparam logic [15:0] BLOCK_DEFAULT = 16'h0001;

    localparam int unsigned EV_TEACH = 0;
    localparam int unsigned EV_SAVE = 1;
    localparam int unsigned EV_SPLIT = 2;
    localparam int unsigned EV_REJECT = 3;
    localparam int unsigned NUM_EV = 4;

    typedef struct packed {
        logic active;
        logic all_beams;
        logic [15:0] start_beam;
        logic [15:0] end_beam;
        logic [15:0] on_count;
        logic [15:0] off_count;
    } scts_area_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } scts_apb_req_t;

    typedef struct packed {
        logic reboot;
        logic erase_user;
        logic save_start;
        logic teach_start;
    } scts_cmd_t;
endpackage
`default_nettype wire

// ==== verilog/scts_cmd_timer.sv ====
/*
 * Busy timer for long commands such as save.
 * Assumes start is a one-cycle pulse.
 */
`default_nettype none
module scts_cmd_timer #(
    parameter int unsigned CYCLES = 60_000_000
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic busy;
        logic done;
    } scts_tmr_t;
    scts_tmr_t st, next_st;
    // Elaboration check on the run length
    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least one");
    end
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (st.busy) begin
            if (st.cnt == 32'(CYCLES - 1)) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 32'h1;
            end
        end else if (start_i) begin
            next_st.busy = 1'b1;
            next_st.cnt = 32'h0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) st <= '0;
        else st <= next_st;
    end
    assign busy_o = st.busy;
    assign done_o = st.done;
endmodule
`default_nettype wire

// ==== verilog/scts_level_scale.sv ====
/*
 * Scales a raw beam signal level by the function reserve selection.
 * Assumes reserve 0 high, 1 medium, 2 low, 3 none (shift 0..3).
 */
`default_nettype none
module scts_level_scale (
    input wire logic [15:0] raw_i,
    input wire logic [1:0] reserve_i,
    output logic [15:0] level_o
);
    // [RQ14] Function reserve scaling
    assign level_o = raw_i >> reserve_i;
endmodule
`default_nettype wire

// ==== verilog/scts_top.sv ====
/*
 * Command interpreter and teach status of a light curtain, as APB registers.
 * Assumes an APB master, a teach engine giving done/fail, and beam threshold tables outside.
 */
// The implementer's own choice: the APB interface to the registers.
`default_nettype none
module scts_top
    import scts_pkg::*;
#(
    parameter int unsigned SAVE_CYC = SAVE_CYCLES,
    parameter int unsigned BEAMS = NUM_BEAMS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic teach_done_i,
    input wire logic teach_fail_i,
    input wire logic [15:0] first_raw_i,
    input wire logic [15:0] last_raw_i,
    output logic [15:0] thr_beam_o,
    input wire logic [7:0] on_thr_i,
    input wire logic [7:0] off_thr_i,
    output scts_pkg::scts_cmd_t cmd_o,
    output logic irq_o
);
    import scts_pkg::*;

    typedef struct packed {
        scts_area_t [MAX_AREAS-1:0] area;
        logic [15:0] arg;
        logic [15:0] block_start;
        logic [5:0] beam_ofs;
        logic [7:0] teach;
        logic [1:0] reserve;
        logic [NUM_EV-1:0] irq_stat;
        logic [NUM_EV-1:0] irq_mask;
        logic [31:0] rdata;
        logic slverr;
        scts_cmd_t cmd;
    } scts_state_t;

    scts_state_t st, next_st;
    logic save_busy, save_done;
    logic [15:0] first_lvl, last_lvl;
    logic access, wr, rd;
    logic [15:0] idx;
    logic [1:0] sub;
    logic [NUM_EV-1:0] ev;
    logic [15:0] step;
    logic [15:0] cnt;
    logic [15:0] acc;

    // Elaboration check on the beam count
    if (BEAMS < MAX_AREAS || BEAMS > 65530) begin : g_bad_beams
        $error("BEAMS out of range");
    end

    scts_cmd_timer #(.CYCLES(SAVE_CYC)) u_timer (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .start_i(st.cmd.save_start),
        .busy_o(save_busy),
        .done_o(save_done)
    );

    scts_level_scale u_first (
        .raw_i(first_raw_i),
        .reserve_i(st.reserve),
        .level_o(first_lvl)
    );

    scts_level_scale u_last (
        .raw_i(last_raw_i),
        .reserve_i(st.reserve),
        .level_o(last_lvl)
    );

    // Address: bits 17:2 hold the index word, sub-index in address bits 1:0
    assign idx = paddr_i[17:2];
    assign sub = paddr_i[1:0];
    assign access = psel_i && penable_i;
    assign wr = access && pwrite_i;
    assign rd = access && !pwrite_i;
    assign pready_o = 1'b1;

    always_comb begin
        next_st = st;
        ev = '0;
        step = '0;
        cnt = '0;
        acc = '0;
        next_st.cmd = '0;
        next_st.slverr = 1'b0;
        next_st.rdata = '0;
        // Teach status busy until done or fail
        if (st.teach == TEACH_BUSY && (teach_done_i || teach_fail_i)) begin
            next_st.teach = teach_fail_i ? TEACH_ERR : TEACH_OK;
            ev[EV_TEACH] = 1'b1;
        end
        if (save_done) ev[EV_SAVE] = 1'b1;
        // [RQ5] Refuse traffic while saving
        if (access && save_busy) begin
            next_st.slverr = 1'b1;
        end else if (wr) begin
            if (idx == IDX_CMD && sub == 2'h2) begin
                // [RQ1] Argument latched first
                next_st.arg = pwdata_i[15:0];
            end else if (idx == IDX_CMD && sub == 2'h1) begin
                // [RQ2] Command dispatch
                case (pwdata_i[15:0])
                    CMD_TEACH: begin
                        // [RQ16] Busy during teach
                        next_st.teach = TEACH_BUSY;
                        next_st.cmd.teach_start = 1'b1;
                    end
                    CMD_REBOOT: next_st.cmd.reboot = 1'b1;
                    // [RQ3] Erase user settings
                    CMD_RESET: next_st.cmd.erase_user = 1'b1;
                    CMD_SAVE: next_st.cmd.save_start = 1'b1;
                    CMD_SPLIT: begin
                        cnt = {8'h00, st.arg[ARG_CNT_MSB:0]};
                        // [RQ17] Reject bad area count
                        if (cnt == 16'h0 || cnt > 16'(MAX_AREAS)) begin
                            ev[EV_REJECT] = 1'b1;
                        end else begin
                            // [RQ6] Equal area split
                            step = 16'(BEAMS) / cnt;
                            for (int i = 0; i < MAX_AREAS; i++) begin
                                // [RQ8] Write area objects
                                if (16'(i) < cnt) begin
                                    // [RQ15] Area fields
                                    next_st.area[i].active = 1'b1;
                                    // [RQ7] Combination select
                                    next_st.area[i].all_beams = st.arg[ARG_AND_BIT];
                                    next_st.area[i].start_beam = acc + 16'h1;
                                    next_st.area[i].end_beam = (16'(i) == cnt - 16'h1) ? 16'(BEAMS) : acc + step;
                                    next_st.area[i].on_count = st.arg[ARG_AND_BIT]
                                        ? next_st.area[i].end_beam - acc : 16'h1;
                                    next_st.area[i].off_count = next_st.area[i].on_count;
                                end else begin
                                    next_st.area[i] = '0;
                                end
                                acc = acc + step;
                            end
                            ev[EV_SPLIT] = 1'b1;
                        end
                    end
                    // [RQ16] Reserved codes start no command, only flag a reject event
                    default: ev[EV_REJECT] = 1'b1;
                endcase
            end else if (idx == IDX_BLOCK) begin
                // [RQ12] Start beam range check
                if (pwdata_i[15:0] >= 16'h1 && pwdata_i[15:0] <= 16'(BEAMS)) begin
                    next_st.block_start = pwdata_i[15:0];
                end else begin
                    next_st.slverr = 1'b1;
                end
            end else if (idx == IDX_IRQ_STAT) begin
                next_st.irq_stat = st.irq_stat & ~pwdata_i[NUM_EV-1:0];
            end else if (idx == IDX_IRQ_MASK) begin
                next_st.irq_mask = pwdata_i[NUM_EV-1:0];
            end else if (idx == IDX_RESERVE) begin
                next_st.reserve = pwdata_i[1:0];
            end else if (idx == IDX_ON_THR || idx == IDX_OFF_THR || idx == IDX_TEACH || idx == IDX_LEVEL) begin
                next_st.slverr = 1'b1;
            end else if (idx >= IDX_AREA0 && idx < IDX_AREA0 + 16'(MAX_AREAS)) begin
                next_st.slverr = 1'b1;
            end else begin
                next_st.slverr = 1'b1;
            end
        end else if (rd) begin
            if (idx == IDX_TEACH) begin
                // [RQ9] Teach status read
                next_st.rdata = {24'h0, st.teach};
            end else if (idx == IDX_ON_THR) begin
                // [RQ10] Switch-on threshold block
                next_st.rdata = {24'h0, on_thr_i};
                next_st.beam_ofs = st.beam_ofs + 6'h1;
            end else if (idx == IDX_OFF_THR) begin
                // [RQ11] Switch-off threshold block
                next_st.rdata = {24'h0, off_thr_i};
                next_st.beam_ofs = st.beam_ofs + 6'h1;
            end else if (idx == IDX_LEVEL) begin
                // [RQ13] First and last beam levels
                next_st.rdata = {16'h0, (sub == 2'h2) ? last_lvl : first_lvl};
            end else if (idx == IDX_BLOCK) begin
                next_st.rdata = {16'h0, st.block_start};
            end else if (idx == IDX_IRQ_STAT) begin
                next_st.rdata = {{(32-NUM_EV){1'b0}}, st.irq_stat};
            end else if (idx == IDX_IRQ_MASK) begin
                next_st.rdata = {{(32-NUM_EV){1'b0}}, st.irq_mask};
            end else if (idx == IDX_RESERVE) begin
                next_st.rdata = {30'h0, st.reserve};
            end else if (idx >= IDX_AREA0 && idx < IDX_AREA0 + 16'(MAX_AREAS)) begin
                case (sub)
                    2'h0: next_st.rdata = {30'h0, st.area[5'(idx - IDX_AREA0)].all_beams,
                                           st.area[5'(idx - IDX_AREA0)].active};
                    2'h1: next_st.rdata = {st.area[5'(idx - IDX_AREA0)].end_beam,
                                           st.area[5'(idx - IDX_AREA0)].start_beam};
                    2'h2: next_st.rdata = {st.area[5'(idx - IDX_AREA0)].off_count,
                                           st.area[5'(idx - IDX_AREA0)].on_count};
                    default: next_st.slverr = 1'b1;
                endcase
            end else begin
                next_st.slverr = 1'b1;
            end
        end
        if (wr && idx == IDX_BLOCK) next_st.beam_ofs = '0;
        // Set wins over clear
        next_st.irq_stat = next_st.irq_stat | ev;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.block_start <= BLOCK_DEFAULT;
            st.teach <= TEACH_OK;
        end else begin
            st <= next_st;
        end
    end

    // Read data and error valid in the access cycle
    always_comb begin
        prdata_o = next_st.rdata;
        pslverr_o = next_st.slverr && access;
    end

    assign thr_beam_o = st.block_start + {10'h0, st.beam_ofs} - 16'h1;
    assign cmd_o = st.cmd;
    assign irq_o = |(st.irq_stat & st.irq_mask);
endmodule
`default_nettype wire

// ==== sim/scts_top_properties.sv ====
/* Checker for scts_top: command pulses, save refusal, write guards.
   Assumes it is bound to scts_top and sees only its ports. */
`default_nettype none
module scts_top_properties
    import scts_pkg::*;
#(
    parameter int unsigned BEAMS = NUM_BEAMS
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pslverr_o,
    input wire scts_pkg::scts_cmd_t cmd_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wa;
    logic wc;
    logic [15:0] cv;
    assign wa = psel_i && penable_i && pwrite_i;
    assign wc = wa && paddr_i == 18'h08801 && !pslverr_o;
    assign cv = pwdata_i[15:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_teach_pulse: assert property (wc && cv == CMD_TEACH |=> cmd_o.teach_start)
        else $error("teach code gave no pulse");
    a_reboot_pulse: assert property (wc && cv == CMD_REBOOT |=> cmd_o.reboot)
        else $error("reboot code gave no pulse");
    a_erase_pulse: assert property (wc && cv == CMD_RESET |=> cmd_o.erase_user)
        else $error("reset code gave no erase pulse");
    a_save_pulse: assert property (wc && cv == CMD_SAVE |=> cmd_o.save_start)
        else $error("save code gave no pulse");
    a_save_refuse: assert property (cmd_o.save_start |=> (!(psel_i && penable_i) || pslverr_o) [*8])
        else $error("access taken while saving");
    a_reserved_quiet: assert property (wc && (cv == 16'h0 || cv == 16'h1 || cv == 16'h7) |=> cmd_o == '0)
        else $error("reserved code started a command");
    a_pulse_single: assert property (cmd_o != '0 |=> cmd_o == '0)
        else $error("command pulse longer than one cycle");
    a_status_ro: assert property (wa && paddr_i == 18'h09001 |-> pslverr_o)
        else $error("teach status write accepted");
    a_block_range: assert property (wa && paddr_i == 18'h0a448 && (pwdata_i == 0 || pwdata_i > BEAMS) |-> pslverr_o)
        else $error("block start out of range accepted");
    c_split: cover property (wc && cv == CMD_SPLIT);
    c_save: cover property (cmd_o.save_start);
    c_irq: cover property (irq_o);
endmodule
bind scts_top scts_top_properties #(.BEAMS(BEAMS)) i_props (.clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pslverr_o, .cmd_o, .irq_o);
`default_nettype wire

// ==== sim/scts_engine_model.sv ====
/* Teach engine and beam threshold table model.
   Assumes the beam index comes from scts_top thr_beam_o. */
`default_nettype none
module scts_engine_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire scts_pkg::scts_cmd_t cmd_i,
    input wire logic fail_i,
    input wire logic [15:0] beam_i,
    output logic done_o,
    output logic fail_o,
    output logic [7:0] on_o,
    output logic [7:0] off_o
);
    import scts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    assign on_o = beam_i[7:0] ^ 8'h5a;
    assign off_o = beam_i[7:0] + 8'h03;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        fail_o <= 1'b0;
        if (srst_i)
            cnt <= 4'h0;
        else if (cmd_i.teach_start)
            cnt <= 4'h6;
        else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            done_o <= cnt == 4'h1 && !fail_i;
            fail_o <= cnt == 4'h1 && fail_i;
        end
    end
endmodule
`default_nettype wire

// ==== sim/scts_top_tb.sv ====
/* Testbench for scts_top: APB register tests against an engine model.
   Assumes package, design and checker are compiled first. */
`default_nettype none
module scts_top_tb;
    import scts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [17:0] pa = '0;
    logic [31:0] pwd = '0;
    logic fail = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, done, tfail, irq;
    logic [15:0] beam;
    logic [7:0] on_thr, off_thr;
    scts_cmd_t cmd;
    int failures = 0;
    int cmp_count = 0;
    logic [32:0] q;
    scts_top #(.SAVE_CYC(20)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .teach_done_i(done), .teach_fail_i(tfail), .first_raw_i(16'h1234),
        .last_raw_i(16'hf00f), .thr_beam_o(beam), .on_thr_i(on_thr), .off_thr_i(off_thr), .cmd_o(cmd),
        .irq_o(irq));
    scts_engine_model i_eng (.clk_i(clk_i), .srst_i(srst_i), .cmd_i(cmd), .fail_i(fail), .beam_i(beam),
        .done_o(done), .fail_o(tfail), .on_o(on_thr), .off_o(off_thr));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [32:0] s, input logic [32:0] x);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic io(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (pready === 1'b1)
                break;
        end
        q = {pslverr, prdata};
        psel <= 1'b0;
        pen <= 1'b0;
        if (n == 50) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic e);
        io(1'b1, a, d);
        chk({32'h0, q[32]}, {32'h0, e});
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] x);
        io(1'b0, a, 32'h0);
        chk(q, {1'b0, x});
    endtask
    task automatic cmdw(input logic [15:0] g, input logic [15:0] c);
        wr(18'h08802, {16'h0, g}, 1'b0);
        wr(18'h08801, {16'h0, c}, 1'b0);
    endtask
    task automatic poll(input logic [17:0] a, input logic [7:0] b);
        int n;
        for (n = 0; n < 40; n++) begin
            io(1'b0, a, 32'h0);
            if (q[32] === 1'b0 && q[7:0] !== b)
                break;
        end
        if (n == 40) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic irqc(input logic x);
        @(posedge clk_i);
        chk({32'h0, irq}, {32'h0, x});
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(18'h0a448, 32'h1);
        rd(18'h09001, 32'h0);
        wr(18'h0a448, 32'h0, 1'b1);
        wr(18'h0a448, 32'd1775, 1'b1);
        wr(18'h0a448, 32'd10, 1'b0);
        for (int i = 0; i <= 64; i++)
            rd(18'h08644, {24'h0, 8'(9 + i % 64) ^ 8'h5a});
        rd(18'h08648, 32'h0d);
        rd(18'h09011, 32'h1234);
        wr(18'h0c008, 32'h2, 1'b0);
        rd(18'h09011, 32'h048d);
        rd(18'h09012, 32'h3c03);
        wr(18'h0c004, 32'hf, 1'b0);
        cmdw(16'h0, CMD_TEACH);
        rd(18'h09001, 32'h1);
        poll(18'h09001, 8'h01);
        chk(q, 33'h0);
        rd(18'h0c000, 32'h1);
        irqc(1'b1);
        wr(18'h0c000, 32'hf, 1'b0);
        irqc(1'b0);
        fail <= 1'b1;
        cmdw(16'h0, CMD_TEACH);
        poll(18'h09001, 8'h01);
        chk(q, 33'h80);
        wr(18'h0c000, 32'hf, 1'b0);
        for (int i = 0; i < 3; i++)
            cmdw(16'h0, i == 2 ? 16'h7 : 16'(i));
        rd(18'h0c000, 32'h8);
        wr(18'h0c004, 32'h0, 1'b0);
        irqc(1'b0);
        wr(18'h0c000, 32'hf, 1'b0);
        cmdw(16'h0102, CMD_SPLIT);
        rd(18'h085c0, 32'h3);
        rd(18'h085c1, {16'd887, 16'd1});
        rd(18'h085c5, {16'd1774, 16'd888});
        rd(18'h085c6, {16'd887, 16'd887});
        cmdw(16'h0001, CMD_SPLIT);
        rd(18'h085c0, 32'h1);
        rd(18'h085c1, {16'd1774, 16'd1});
        rd(18'h085c2, 32'h00010001);
        rd(18'h085c4, 32'h0);
        cmdw(16'h0020, CMD_SPLIT);
        rd(18'h0863d, {16'd1774, 16'd1706});
        for (int i = 0; i < 2; i++)
            cmdw(i ? 16'd33 : 16'd0, CMD_SPLIT);
        rd(18'h0863d, {16'd1774, 16'd1706});
        rd(18'h0c000, 32'hc);
        wr(18'h0c000, 32'hf, 1'b0);
        cmdw(16'h0, CMD_RESET);
        cmdw(16'h0, CMD_REBOOT);
        cmdw(16'h0, CMD_SAVE);
        io(1'b0, 18'h09001, 32'h0);
        chk({32'h0, q[32]}, 33'h1);
        wr(18'h0c004, 32'hf, 1'b1);
        poll(18'h0c000, 8'h00);
        chk(q, 33'h2);
        irqc(1'b0);
        io(1'b0, 18'h01000, 32'h0);
        chk({32'h0, q[32]}, 33'h1);
        wr(18'h09001, 32'h0, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
